// ===== rtl/adcsp_params.svh
`ifndef ADCSP_PARAMS_SVH
`define ADCSP_PARAMS_SVH
// Register select codes
`define ADCSP_REG_STAT 4'h0
`define ADCSP_REG_CONTROL_ONE 4'h1
`define ADCSP_REG_GPIO_DIRECTION_AND_LEVEL 4'h2
`define ADCSP_REG_CONTROL_THREE 4'h3
`define ADCSP_REG_DATA 4'h4
`define ADCSP_REG_SOC 4'h5
`define ADCSP_REG_SGC 4'h6
`define ADCSP_REG_SELF_OFFSET_COEFF 4'h7
`define ADCSP_REG_SELF_GAIN_COEFF 4'h8
// Power-on values
`define ADCSP_RST_BYTE 8'h00
`define ADCSP_RST_CONTROL_ONE 8'h02
`define ADCSP_RST_GPIO_DIRECTION_AND_LEVEL 8'h0f
`define ADCSP_RST_CONTROL_THREE 8'h1e
`define ADCSP_RST_WORD 24'h000000
// Command byte fields
`define ADCSP_CMD_MODE 6
`define ADCSP_CMD_ZERO 5
`define ADCSP_CMD_CAL_HI 5
`define ADCSP_CMD_CAL_LO 4
`define ADCSP_CMD_PD 3
`define ADCSP_CMD_RATE_HI 2
`define ADCSP_CMD_RATE_LO 0
`define ADCSP_CMD_RS_HI 4
`define ADCSP_CMD_RS_LO 1
`define ADCSP_CMD_RD 0
// Control one fields
`define ADCSP_C1_UNIPOLAR 6
`define ADCSP_C1_FORMAT 2
`define ADCSP_C1_SINGLE 1
// Control two fields
`define ADCSP_C2_DIR_HI 7
`define ADCSP_C2_DIR_LO 4
`define ADCSP_C2_LVL_HI 3
`define ADCSP_C2_LVL_LO 0
// Control three fields
`define ADCSP_C3_GAIN_HI 7
`define ADCSP_C3_GAIN_LO 5
`define ADCSP_C3_DIS_HI 4
`define ADCSP_C3_DIS_LO 1
// Calibration select codes
`define ADCSP_CAL_NONE 2'h0
`define ADCSP_CAL_SELF 2'h1
`define ADCSP_CAL_SYSOFF 2'h2
`define ADCSP_CAL_SYSGAIN 2'h3
// Frame lengths and settling
`define ADCSP_LAST_BYTE 5'h07
`define ADCSP_LAST_WORD 5'h17
`define ADCSP_SETTLE_DROP 2'h3
`endif

// ===== rtl/adcsp_pkg.sv
package adcsp_pkg;
  typedef enum logic [1:0] {ADCSP_IDLE, ADCSP_CMD, ADCSP_RD, ADCSP_WR} adcsp_state_t;
endpackage

// ===== rtl/adcsp_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "adcsp_params.svh"
module adcsp_port import adcsp_pkg::*; #(
  parameter int RES_BITS = 18,
  parameter bit HAS_GAIN = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_din,
  output logic rdy_dout_r,
  output logic rdy_dout_oe_n_r,
  // General-purpose pins
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out_r,
  output logic [3:0] gpio_oe_n_r,
  // Conversion core requests
  output logic op_start_r,
  output logic op_abort_r,
  output logic op_powerdown_r,
  output logic [1:0] op_cal_sel_r,
  output logic [2:0] op_rate_r,
  // Configuration to the core
  output logic [7:0] control_one_r,
  output logic [7:0] control_three_r,
  output logic [23:0] sys_offset_coeff_r,
  output logic [23:0] system_gain_coeff_r,
  output logic [23:0] self_offset_coeff_r,
  output logic [23:0] self_gain_coeff_r,
  // Core status
  input wire logic core_busy,
  input wire logic conv_begin,
  input wire logic cal_done,
  input wire logic [23:0] cal_offset,
  input wire logic [23:0] cal_gain,
  input wire logic cal_overrange,
  // Result stream
  input wire logic res_valid,
  input wire logic [RES_BITS-1:0] res_data,
  output logic res_ready
);
  if (RES_BITS != 18) begin : g_bad_res
    $error("adcsp_port: result path is built for 18 bits");
  end

  localparam logic signed [25:0] RES_MAX = 26'sh001ffff;
  localparam logic signed [25:0] RES_MIN = -26'sh0020000;

  // Pin synchronisers; first stages feed only second stages
  logic cs_s1, cs_s2, sclk_s1, sclk_s2, sclk_s3, din_s1, din_s2;
  logic [3:0] gpio_s1, gpio_s2;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
      gpio_s1 <= 4'h0;
      gpio_s2 <= 4'h0;
    end else begin
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      din_s1 <= spi_din;
      din_s2 <= din_s1;
      gpio_s1 <= gpio_in;
      gpio_s2 <= gpio_s1;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s2 && !sclk_s3;
  assign sclk_fall = !sclk_s2 && sclk_s3;

  // Status and data state
  logic rdy_r, rd_pend_r, sys_gain_overrange_r, over_r, under_r;
  logic [2:0] stat_rate_r;
  logic [7:0] control_two_r;
  logic [23:0] data_r;
  logic [7:0] stat_w;
  assign stat_w = {sys_gain_overrange_r, stat_rate_r, over_r, under_r, core_busy, rdy_r};

  function automatic logic reg_wide(input logic [3:0] sel);
    reg_wide = (sel >= `ADCSP_REG_DATA) && (sel <= `ADCSP_REG_SELF_GAIN_COEFF);
  endfunction

  function automatic logic [23:0] reg_read(input logic [3:0] sel);
    unique case (sel)
      `ADCSP_REG_STAT: reg_read = {16'h0000, stat_w};
      `ADCSP_REG_CONTROL_ONE: reg_read = {16'h0000, control_one_r};
      `ADCSP_REG_GPIO_DIRECTION_AND_LEVEL: reg_read = {16'h0000, control_two_r[7:4],
        (control_two_r[7:4] & control_two_r[3:0]) | (~control_two_r[7:4] & gpio_s2)};
      `ADCSP_REG_CONTROL_THREE: reg_read = {16'h0000, control_three_r};
      `ADCSP_REG_DATA: reg_read = data_r;
      `ADCSP_REG_SOC: reg_read = sys_offset_coeff_r;
      `ADCSP_REG_SGC: reg_read = system_gain_coeff_r;
      `ADCSP_REG_SELF_OFFSET_COEFF: reg_read = self_offset_coeff_r;
      `ADCSP_REG_SELF_GAIN_COEFF: reg_read = self_gain_coeff_r;
      default: reg_read = `ADCSP_RST_WORD;
    endcase
  endfunction

  // Serial engine
  adcsp_state_t st_r;
  logic [23:0] sh_r;
  logic [4:0] cnt_r;
  logic [3:0] sel_r;
  logic wide_r, wr_stb_r, op_stb_r, rd_data_done_r;
  logic [7:0] cmd_r;
  logic [23:0] wr_val_r;
  logic [7:0] byte_w;
  logic [4:0] last_w;
  assign byte_w = {sh_r[6:0], din_s2};
  assign last_w = wide_r ? `ADCSP_LAST_WORD : `ADCSP_LAST_BYTE;

  always_ff @(posedge sys_clk) begin
    wr_stb_r <= 1'b0;
    op_stb_r <= 1'b0;
    rd_data_done_r <= 1'b0;
    if (sys_rst) begin
      st_r <= ADCSP_IDLE;
      sh_r <= `ADCSP_RST_WORD;
      cnt_r <= 5'h00;
      sel_r <= 4'h0;
      wide_r <= 1'b0;
      cmd_r <= `ADCSP_RST_BYTE;
      wr_val_r <= `ADCSP_RST_WORD;
      rdy_dout_r <= 1'b1;
      rdy_dout_oe_n_r <= 1'b1;
    end else if (cs_s2) begin
      st_r <= ADCSP_IDLE;
      cnt_r <= 5'h00;
      rdy_dout_oe_n_r <= 1'b1;
    end else begin
      rdy_dout_oe_n_r <= 1'b0;
      unique case (st_r)
        ADCSP_IDLE: begin
          st_r <= ADCSP_CMD;
        end
        ADCSP_CMD: begin
          if (cnt_r == 5'h00) begin
            rdy_dout_r <= ~rdy_r;
          end
          // Leading zeros are idle clocks, so framing survives select tied low
          if (sclk_rise && !(cnt_r == 5'h00 && !din_s2)) begin
            sh_r <= {sh_r[22:0], din_s2};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `ADCSP_LAST_BYTE) begin
              cnt_r <= 5'h00;
              if (!byte_w[`ADCSP_CMD_MODE]) begin
                cmd_r <= byte_w;
                op_stb_r <= 1'b1;
              end else if (!byte_w[`ADCSP_CMD_ZERO]) begin
                sel_r <= byte_w[`ADCSP_CMD_RS_HI:`ADCSP_CMD_RS_LO];
                wide_r <= reg_wide(byte_w[`ADCSP_CMD_RS_HI:`ADCSP_CMD_RS_LO]);
                if (byte_w[`ADCSP_CMD_RD]) begin
                  st_r <= ADCSP_RD;
                  sh_r <= reg_read(byte_w[`ADCSP_CMD_RS_HI:`ADCSP_CMD_RS_LO])
                    << (reg_wide(byte_w[`ADCSP_CMD_RS_HI:`ADCSP_CMD_RS_LO]) ? 5'h00 : 5'h10);
                end else begin
                  st_r <= ADCSP_WR;
                end
              end
            end
          end
        end
        ADCSP_RD: begin
          if (sclk_fall) begin
            rdy_dout_r <= sh_r[23];
            sh_r <= {sh_r[22:0], 1'b0};
          end
          if (sclk_rise) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == last_w) begin
              cnt_r <= 5'h00;
              st_r <= ADCSP_CMD;
              rd_data_done_r <= (sel_r == `ADCSP_REG_DATA);
            end
          end
        end
        ADCSP_WR: begin
          if (sclk_rise) begin
            sh_r <= {sh_r[22:0], din_s2};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == last_w) begin
              cnt_r <= 5'h00;
              st_r <= ADCSP_CMD;
              wr_stb_r <= 1'b1;
              wr_val_r <= {sh_r[22:0], din_s2};
            end
          end
        end
      endcase
    end
  end

  // Operation requests to the core
  logic start_w;
  assign start_w = op_stb_r && !cmd_r[`ADCSP_CMD_PD];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_start_r <= 1'b0;
      op_abort_r <= 1'b0;
      op_powerdown_r <= 1'b0;
      op_cal_sel_r <= `ADCSP_CAL_NONE;
      op_rate_r <= 3'h0;
      stat_rate_r <= 3'h0;
    end else begin
      op_start_r <= start_w;
      op_powerdown_r <= op_stb_r && cmd_r[`ADCSP_CMD_PD];
      op_abort_r <= op_stb_r && core_busy;
      if (start_w) begin
        op_cal_sel_r <= cmd_r[`ADCSP_CMD_CAL_HI:`ADCSP_CMD_CAL_LO];
        op_rate_r <= cmd_r[`ADCSP_CMD_RATE_HI:`ADCSP_CMD_RATE_LO];
        stat_rate_r <= cmd_r[`ADCSP_CMD_RATE_HI:`ADCSP_CMD_RATE_LO];
      end
    end
  end

  // Register file; a calibration result beats a host write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      control_one_r <= `ADCSP_RST_CONTROL_ONE;
      control_two_r <= `ADCSP_RST_GPIO_DIRECTION_AND_LEVEL;
      control_three_r <= `ADCSP_RST_CONTROL_THREE;
      sys_offset_coeff_r <= `ADCSP_RST_WORD;
      system_gain_coeff_r <= `ADCSP_RST_WORD;
      self_offset_coeff_r <= `ADCSP_RST_WORD;
      self_gain_coeff_r <= `ADCSP_RST_WORD;
      sys_gain_overrange_r <= 1'b0;
    end else begin
      if (wr_stb_r) begin
        unique case (sel_r)
          `ADCSP_REG_CONTROL_ONE: control_one_r <= wr_val_r[7:0];
          `ADCSP_REG_GPIO_DIRECTION_AND_LEVEL: control_two_r <= wr_val_r[7:0];
          `ADCSP_REG_CONTROL_THREE: control_three_r <= wr_val_r[7:0];
          `ADCSP_REG_SOC: sys_offset_coeff_r <= wr_val_r;
          `ADCSP_REG_SGC: system_gain_coeff_r <= wr_val_r;
          `ADCSP_REG_SELF_OFFSET_COEFF: self_offset_coeff_r <= wr_val_r;
          `ADCSP_REG_SELF_GAIN_COEFF: self_gain_coeff_r <= wr_val_r;
          default: ;
        endcase
      end
      if (cal_done) begin
        unique case (op_cal_sel_r)
          `ADCSP_CAL_SELF: begin
            self_offset_coeff_r <= cal_offset;
            self_gain_coeff_r <= cal_gain;
          end
          `ADCSP_CAL_SYSOFF: sys_offset_coeff_r <= cal_offset;
          `ADCSP_CAL_SYSGAIN: begin
            system_gain_coeff_r <= cal_gain;
            sys_gain_overrange_r <= cal_overrange;
          end
          default: ;
        endcase
      end
    end
  end

  // Pins follow the direction and level nibbles
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gpio_out_r <= 4'(`ADCSP_RST_GPIO_DIRECTION_AND_LEVEL);
      gpio_oe_n_r <= 4'hf;
    end else begin
      gpio_out_r <= control_two_r[`ADCSP_C2_LVL_HI:`ADCSP_C2_LVL_LO];
      gpio_oe_n_r <= ~control_two_r[`ADCSP_C2_DIR_HI:`ADCSP_C2_DIR_LO];
    end
  end

  // Result path: buffer lets a data readout stall the core without loss
  logic buf_valid, take_w, drain_rdy;
  logic [RES_BITS-1:0] buf_data;
  assign drain_rdy = !(st_r == ADCSP_RD && sel_r == `ADCSP_REG_DATA);
  assign take_w = buf_valid && drain_rdy;

  adcsp_skid #(.WIDTH(RES_BITS)) u_skid (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(res_valid),
    .in_data(res_data),
    .in_ready(res_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(drain_rdy)
  );

  // Gain with clipping: {over, under, value}
  function automatic logic [RES_BITS+1:0] gain_clip(input logic [RES_BITS-1:0] v,
                                                   input logic [2:0] g);
    logic signed [25:0] ext;
    ext = 26'(signed'(v)) <<< (HAS_GAIN ? g : 3'h0);
    if (ext > RES_MAX) begin
      gain_clip = {2'b10, RES_MAX[RES_BITS-1:0]};
    end else if (ext < RES_MIN) begin
      gain_clip = {2'b01, RES_MIN[RES_BITS-1:0]};
    end else begin
      gain_clip = {2'b00, ext[RES_BITS-1:0]};
    end
  endfunction

  logic [RES_BITS+1:0] clip_w;
  logic [RES_BITS-1:0] fmt_w;
  logic [1:0] settle_r;
  logic load_w;
  assign clip_w = gain_clip(buf_data, control_three_r[`ADCSP_C3_GAIN_HI:`ADCSP_C3_GAIN_LO]);
  assign fmt_w = (control_one_r[`ADCSP_C1_UNIPOLAR] || control_one_r[`ADCSP_C1_FORMAT])
    ? {~clip_w[RES_BITS-1], clip_w[RES_BITS-2:0]} : clip_w[RES_BITS-1:0];
  assign load_w = take_w && (settle_r == 2'h0);

  // Continuous mode hides the filter's first unsettled results
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      settle_r <= 2'h0;
    end else if (op_start_r && op_cal_sel_r == `ADCSP_CAL_NONE) begin
      settle_r <= control_one_r[`ADCSP_C1_SINGLE] ? 2'h0 : `ADCSP_SETTLE_DROP;
    end else if (take_w && settle_r != 2'h0) begin
      settle_r <= settle_r - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_r <= `ADCSP_RST_WORD;
      over_r <= 1'b0;
      under_r <= 1'b0;
    end else if (load_w) begin
      data_r <= {{(24 - RES_BITS){1'b0}}, fmt_w};
      over_r <= clip_w[RES_BITS+1];
      under_r <= clip_w[RES_BITS];
    end
  end

  // Ready flag; a new result wins over a clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdy_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else if (load_w) begin
      rdy_r <= 1'b1;
      rd_pend_r <= 1'b0;
    end else if (rd_data_done_r && core_busy) begin
      rdy_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else if (rd_data_done_r) begin
      rd_pend_r <= 1'b1;
    end else if (rd_pend_r && conv_begin) begin
      rdy_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end
  end

  property p_cs_release;
    @(posedge sys_clk) disable iff (sys_rst) cs_s2 |=> rdy_dout_oe_n_r && st_r == ADCSP_IDLE;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("output not released");

  property p_write_on_rise;
    @(posedge sys_clk) disable iff (sys_rst)
      !cs_s2 && st_r == ADCSP_WR && sclk_rise && cnt_r == last_w |=> wr_stb_r ##1 !wr_stb_r;
  endproperty
  a_write_on_rise: assert property (p_write_on_rise) else $error("write not taken");

  property p_out_on_fall;
    @(posedge sys_clk) disable iff (sys_rst)
      st_r == ADCSP_RD && $past(st_r) == ADCSP_RD && $changed(rdy_dout_r) |-> $past(sclk_fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off fall");

  property p_msb_first;
    @(posedge sys_clk) disable iff (sys_rst)
      !cs_s2 && st_r == ADCSP_RD && sclk_fall |=> rdy_dout_r == $past(sh_r[23]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

  property p_status_level;
    @(posedge sys_clk) disable iff (sys_rst)
      !cs_s2 && st_r == ADCSP_CMD && cnt_r == 5'h00 |=> rdy_dout_r == !$past(rdy_r);
  endproperty
  a_status_level: assert property (p_status_level) else $error("status level wrong");

  property p_op_decode;
    @(posedge sys_clk) disable iff (sys_rst)
      start_w |=> op_start_r && op_rate_r == $past(cmd_r[2:0]) && !op_powerdown_r;
  endproperty
  a_op_decode: assert property (p_op_decode) else $error("operation mis-decoded");

  property p_start_sync;
    @(posedge sys_clk) disable iff (sys_rst)
      !cs_s2 && st_r == ADCSP_CMD && cnt_r == 5'h00 && sclk_rise && !din_s2 |=> cnt_r == 5'h00;
  endproperty
  a_start_sync: assert property (p_start_sync) else $error("zero start bit counted");

  property p_ready_set;
    @(posedge sys_clk) disable iff (sys_rst) load_w |=> rdy_r && stat_w[0];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set");

  property p_ready_clear;
    @(posedge sys_clk) disable iff (sys_rst) rd_data_done_r && core_busy && !load_w |=> !rdy_r;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

  property p_gpio;
    @(posedge sys_clk) disable iff (sys_rst)
      wr_stb_r && sel_r == `ADCSP_REG_GPIO_DIRECTION_AND_LEVEL |=> ##1 gpio_oe_n_r == ~$past(wr_val_r[7:4], 2);
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin direction wrong");

  property p_abort;
    @(posedge sys_clk) disable iff (sys_rst) op_stb_r && core_busy |=> op_abort_r;
  endproperty
  a_abort: assert property (p_abort) else $error("abort missing");

  c_read_data: cover property (@(posedge sys_clk) disable iff (sys_rst) rd_data_done_r);
  c_write: cover property (@(posedge sys_clk) disable iff (sys_rst) wr_stb_r);
  c_start: cover property (@(posedge sys_clk) disable iff (sys_rst) op_start_r);
  c_stall: cover property (@(posedge sys_clk) disable iff (sys_rst) buf_valid && !drain_rdy);
endmodule
`default_nettype wire

// ===== rtl/adcsp_skid.sv
`timescale 1ns/10ps
`default_nettype none
module adcsp_skid #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;

  if (WIDTH < 1) begin : g_bad_width
    $error("adcsp_skid: WIDTH must be at least 1");
  end

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_r <= 2'h0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != 2'h2);
      out_valid <= (cnt_nxt != 2'h0);
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
    end
  end

  // Storage needs no reset; the count guards it
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== tb/adcsp_host.sv
`timescale 1ns/10ps
`default_nettype none
module adcsp_host (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_din,
  input wire logic rdy_dout_r
);
  logic hold_cs = 1'h0;
  initial begin
    spi_cs_n = 1'h1;
    spi_sclk = 1'h0;
    spi_din = 1'h0;
  end
  task automatic hop(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Clock stands still and data flips outside frames
  task automatic xfer(input logic [7:0] cmd, input int nb, input logic [23:0] wd,
                      output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd << (24 - nb)};
    rd = '0;
    spi_cs_n = 1'h0;
    hop(4);
    for (int i = 0; i < 8 + nb; i++) begin
      spi_din = sh[31 - i];
      hop(4);
      if (i >= 8) rd = {rd[22:0], rdy_dout_r};
      spi_sclk = 1'h1;
      hop(4);
      spi_sclk = 1'h0;
    end
    hop(4);
    spi_cs_n = !hold_cs;
    spi_din = ~spi_din;
    hop(2);
  endtask
  task automatic peek(output logic v);
    spi_cs_n = 1'h0;
    hop(8);
    v = rdy_dout_r;
    spi_cs_n = 1'h1;
    hop(4);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_adc_serial_command_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "adcsp_params.svh"
module tb_adc_serial_command_port;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  wire logic spi_cs_n, spi_sclk, spi_din;
  logic rdy_dout_r, rdy_dout_oe_n_r, op_start_r, op_abort_r, op_powerdown_r, res_ready;
  logic [3:0] gpio_in = 4'h0;
  logic [3:0] gpio_out_r, gpio_oe_n_r;
  logic [1:0] op_cal_sel_r;
  logic [2:0] op_rate_r;
  logic [7:0] control_one_r, control_three_r;
  logic [23:0] sys_offset_coeff_r, system_gain_coeff_r, self_offset_coeff_r, self_gain_coeff_r;
  logic core_busy = 1'h0, conv_begin = 1'h0, cal_done = 1'h0, cal_overrange = 1'h0;
  logic res_valid = 1'h0;
  logic [23:0] cal_offset = '0, cal_gain = '0;
  logic [17:0] res_data = '0;
  int error_cnt = 0, n_tests = 0, n_st = 0, n_ab = 0, n_pd = 0;
  int seed = 32'h478ec576;
  adcsp_port DUT (.sys_clk, .sys_rst, .spi_cs_n, .spi_sclk, .spi_din, .rdy_dout_r,
    .rdy_dout_oe_n_r, .gpio_in, .gpio_out_r, .gpio_oe_n_r, .op_start_r, .op_abort_r,
    .op_powerdown_r, .op_cal_sel_r, .op_rate_r, .control_one_r, .control_three_r,
    .sys_offset_coeff_r, .system_gain_coeff_r, .self_offset_coeff_r, .self_gain_coeff_r,
    .core_busy, .conv_begin, .cal_done, .cal_offset, .cal_gain, .cal_overrange,
    .res_valid, .res_data, .res_ready);
  wire logic dout_pin;
  // Released line shows the inverse so no stale level can pass
  assign dout_pin = rdy_dout_oe_n_r ? ~rdy_dout_r : rdy_dout_r;
  adcsp_host host (.sys_clk, .spi_cs_n, .spi_sclk, .spi_din, .rdy_dout_r(dout_pin));
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (op_start_r === 1'h1) n_st++;
    if (op_powerdown_r === 1'h1) n_pd++;
    if (op_abort_r === 1'h1) n_ab++;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic acc(input logic [3:0] s, input logic w, input logic [23:0] d,
                     output logic [23:0] v);
    host.xfer({3'h6, s, ~w}, (s > 4'h3 && s < 4'h9) ? 24 : 8, d, v);
  endtask
  // Result handshake: hold valid until ready seen at an edge
  task automatic push(input logic [17:0] d);
    res_valid = 1'h1;
    res_data = d;
    while (res_ready !== 1'h1) tick(1);
    tick(1);
    res_valid = 1'h0;
    tick(4);
  endtask
  initial begin
    #1500000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    logic [23:0] v, e;
    logic [7:0] c;
    static logic [23:0] rv [10] = '{`ADCSP_RST_BYTE, `ADCSP_RST_CONTROL_ONE, `ADCSP_RST_GPIO_DIRECTION_AND_LEVEL,
      `ADCSP_RST_CONTROL_THREE, `ADCSP_RST_WORD, `ADCSP_RST_WORD, `ADCSP_RST_WORD,
      `ADCSP_RST_WORD, `ADCSP_RST_WORD, 24'h0};
    static logic [7:0] gp [4] = '{8'h00, 8'hf1, 8'hf0, 8'hf4};
    gpio_in = 4'($random(seed));
    tick(4);
    sys_rst = 1'h0;
    tick(4);
    chk(rdy_dout_oe_n_r, 1'h1);
    for (int s = 0; s < 10; s++) begin
      acc(s[3:0], 1'h0, '0, v);
      chk(v, (s == 2) ? {20'h0, gpio_in} : rv[s]);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'($random(seed)) : gp[i];
      acc(4'h2, 1'h1, {16'h0, c}, v);
      chk(gpio_out_r, c[3:0]);
      chk(gpio_oe_n_r, 4'(~c[7:4]));
      acc(4'h2, 1'h0, '0, v);
      chk(v, {16'h0, c[7:4], (c[7:4] & c[3:0]) | (~c[7:4] & gpio_in)});
    end
    for (int s = 5; s < 9; s++) begin
      e = 24'($random(seed));
      acc(s[3:0], 1'h1, e, v);
      acc(s[3:0], 1'h0, '0, v);
      chk(v, e);
    end
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      c = (i < 3) ? 8'h90 + 8'h10 * i[7:0] : (i == 3) ? 8'h88 : 8'h7c + i[7:0];
      core_busy = (i == 5);
      n_st = 0;
      n_pd = 0;
      n_ab = 0;
      host.xfer(c, 0, '0, v);
      tick(4);
      chk(24'(n_st + 2 * n_pd + 4 * n_ab), 24'(c[3] ? 2 : (i == 5) ? 5 : 1));
      if (!c[3]) chk({op_cal_sel_r, op_rate_r}, {c[5:4], c[2:0]});
      core_busy = 1'h0;
      if (c[5:4] != 2'h0) begin
        cal_offset = 24'($random(seed));
        cal_gain = 24'($random(seed));
        cal_overrange = (c[5:4] == 2'h3);
        cal_done = 1'h1;
        tick(1);
        cal_done = 1'h0;
        tick(2);
        case (c[5:4])
          2'h1: chk(self_offset_coeff_r, cal_offset);
          2'h2: chk(sys_offset_coeff_r, cal_offset);
          default: chk(system_gain_coeff_r, cal_gain);
        endcase
      end
    end
    acc(4'h0, 1'h1, 24'h0f, v);
    acc(4'h0, 1'h0, '0, v);
    chk(v, 24'hf0);
    $display("test operations done");
    for (int g = 0; g < 9; g++) begin
      acc(4'h3, 1'h1, {16'h0, g[2:0], 5'h1e}, v);
      if (g == 8) acc(4'h1, 1'h1, 24'h06, v);
      e = 24'($random(seed)) & (g[3] ? 24'h03ffff : 24'h0000ff);
      push(e[17:0]);
      host.peek(c[0]);
      chk(c[0], 1'h0);
      core_busy = (g == 7);
      acc(4'h4, 1'h0, '0, v);
      core_busy = 1'h0;
      chk(v, g[3] ? e ^ 24'h020000 : e << g[2:0]);
      host.peek(c[0]);
      chk(c[0], 1'(g == 7));
      conv_begin = 1'h1;
      tick(1);
      conv_begin = 1'h0;
      host.peek(c[0]);
      chk(c[0], 1'h1);
    end
    $display("test results done");
    host.hold_cs = 1'h1;
    acc(4'h1, 1'h1, 24'h40, v);
    host.xfer(8'h84, 0, '0, v);
    host.hold_cs = 1'h0;
    for (int k = 0; k < 4; k++) begin
      e = 24'($random(seed)) & 24'h0000ff;
      push(e[17:0]);
      host.peek(c[0]);
      chk(c[0], 24'(k < 3));
    end
    acc(4'h4, 1'h0, '0, v);
    chk(v, e ^ 24'h020000);
    $display("test continuous done");
    wrap_up();
  end
endmodule
`default_nettype wire
